// File: verilog/csp_pkg.sv
// Package for the clocked serial port: register offsets, reset values,
// field positions and prescaler half periods.
// Assumes a 16-bit register address and 8-bit register data.
package csp_pkg;
  localparam logic [15:0] OFS_MODE = 16'hffb0;
  localparam logic [15:0] OFS_DATA_HI = 16'hffb1;
  localparam logic [15:0] OFS_DATA_LO = 16'hffb2;
  localparam logic [15:0] OFS_LAST_BIT = 16'hffb3;
  localparam logic [15:0] OFS_PIN_FUNC = 16'hffec;
  localparam logic [15:0] OFS_DRV_SEL = 16'hffed;

  localparam logic [7:0] RST_MODE = 8'h80;
  localparam logic [7:0] RST_PIN_FUNC = 8'h00;
  localparam logic [7:0] RST_DRV_SEL = 8'h97;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] READ_ONES = 8'hff;
  localparam logic [7:0] LAST_BIT_FILL = 8'h7f;

  // Mode register fields
  localparam int MODE_WL_BIT = 6;
  localparam int MODE_SEL_HI = 5;
  localparam int MODE_SEL_LO = 4;
  localparam int MODE_CLK_HI = 3;
  // Pin function and driver fields
  localparam int PIN_OUT_BIT = 3;
  localparam int PIN_IN_BIT = 2;
  localparam int PIN_CLK_BIT = 1;
  localparam int DRV_OD_BIT = 3;
  localparam int LAST_BIT_POS = 7;

  localparam logic [3:0] CLK_EXTERNAL = 4'h f;
  localparam logic [4:0] BITS_SHORT = 5'h08;
  localparam logic [4:0] BITS_LONG = 5'h10;

  // Half periods minus one, in system clocks, for divisions 1024 down to 2
  localparam logic [9:0] HALF_1024 = 10'h1ff;
  localparam logic [9:0] HALF_256 = 10'h07f;
  localparam logic [9:0] HALF_64 = 10'h01f;
  localparam logic [9:0] HALF_32 = 10'h00f;
  localparam logic [9:0] HALF_16 = 10'h007;
  localparam logic [9:0] HALF_8 = 10'h003;
  localparam logic [9:0] HALF_4 = 10'h001;
  localparam logic [9:0] HALF_2 = 10'h000;
endpackage

// File: verilog/csp_clk_if.sv
// Link between the serial core and its clock generator.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface csp_clk_if;
  logic ce;
  logic [3:0] sel;
  logic run;
  logic restart;
  logic lvl;
  logic fall;
  logic rise;
  modport gen (input ce, input sel, input run, input restart, output lvl, output fall,
    output rise);
  modport core (output ce, output sel, output run, output restart, input lvl, input fall,
    input rise);
endinterface
`default_nettype wire

// File: verilog/csp_clkgen.sv
// Serial clock generator: prescaled internal clock or synchronised external pin.
// Assumes the clock pin input is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module csp_clkgen (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sck_in,
  csp_clk_if.gen cif
);
  logic [9:0] cnt, next_cnt;
  logic lvl, next_lvl;
  logic sync_a, sync_b;
  logic ext;

  // Half period for each internal clock code
  function automatic logic [9:0] half_of(input logic [3:0] sel);
    case (sel[2:0])
      3'h0: half_of = csp_pkg::HALF_1024;
      3'h1: half_of = csp_pkg::HALF_256;
      3'h2: half_of = csp_pkg::HALF_64;
      3'h3: half_of = csp_pkg::HALF_32;
      3'h4: half_of = csp_pkg::HALF_16;
      3'h5: half_of = csp_pkg::HALF_8;
      3'h6: half_of = csp_pkg::HALF_4;
      default: half_of = csp_pkg::HALF_2;
    endcase
  endfunction

  assign ext = (cif.sel == csp_pkg::CLK_EXTERNAL);
  assign cif.lvl = lvl;

  // Next level and edge events; clock idles high
  always_comb begin
    next_cnt = cnt;
    next_lvl = lvl;
    cif.fall = 1'b0;
    cif.rise = 1'b0;
    if (ext) begin
      next_cnt = '0;
      next_lvl = sync_b;
      cif.fall = cif.ce & cif.run & lvl & ~sync_b;
      cif.rise = cif.ce & cif.run & ~lvl & sync_b;
    end else if (cif.restart || !cif.run || cif.sel[3]) begin
      next_cnt = '0;
      next_lvl = 1'b1;
    end else if (cnt == half_of(cif.sel)) begin
      next_cnt = '0;
      next_lvl = ~lvl;
      cif.fall = cif.ce & lvl;
      cif.rise = cif.ce & ~lvl;
    end else begin
      next_cnt = cnt + 10'h001;
    end
  end

  // Registers, frozen while clock enable is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
      lvl <= 1'b1;
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else if (cif.ce) begin
      cnt <= next_cnt;
      lvl <= next_lvl;
      sync_a <= sck_in;
      sync_b <= sync_a;
    end
  end
endmodule
`default_nettype wire

// File: verilog/csp_top.sv
// Clocked serial port core: registers, shift chain, bit counter, pins.
// Assumes a single-cycle register port and a clock pin resolved outside.
//
// What this block does
// - Clock-synchronous serial transfers of 8 or 16 bits.
// - Request an interrupt at transfer end and on abort.
// - Three pins: two-way clock, data in, data out.
// - Mode write restarts the serial clock (left stopped unless continuous) and clears the bit counter.
// - Mode write during a transfer aborts it and requests an interrupt.
// - Mode register is 8-bit write-only; top bit reads 1.
// - Reset selects continuous clock output and the slowest division.
// - Mode select low bits 00 give continuous clock output.
// - Nonzero low bits: word length bit picks 8 or 16 bits.
// - Codes 0 to 7 drive a prescaled clock, 1024 down to 2.
// - Code 15 takes an external clock; codes 8 to 14 unused.
// - In 16-bit words the upper byte holds the top 8 bits.
// - Upper byte shifts LSB first into the lower byte.
// - Input sampled on rising edges, LSB first, shifting toward LSB.
// - Lower byte drives the output pin LSB first on falling edges.
// - Last-bit register follows the output stage and sets the pin.
// - Pin function bits choose transmit or receive.
`timescale 1ns/1ps
`default_nettype none
module csp_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_pin_oe,
  output logic serial_irq_flag_set
);
  csp_clk_if cif ();

  logic [7:0] mode, next_mode;
  logic [7:0] data_hi, next_data_hi;
  logic [7:0] data_lo, next_data_lo;
  logic last_bit, next_last_bit;
  logic [2:0] pin_func, next_pin_func;
  logic drv_od, next_drv_od;
  logic busy, next_busy;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic irq, next_irq;
  logic [7:0] next_rdata;
  logic next_sck_out, next_sck_oe, next_sout, next_sout_oe;
  logic si_a, si_b;
  logic wr_mode, wr_hi, wr_lo, wr_last;
  logic continuous, long_word, clk_valid, in_bit;

  // Address decode of the register port
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_mode = wr & hit(addr, csp_pkg::OFS_MODE);
  assign wr_hi = wr & hit(addr, csp_pkg::OFS_DATA_HI);
  assign wr_lo = wr & hit(addr, csp_pkg::OFS_DATA_LO);
  assign wr_last = wr & hit(addr, csp_pkg::OFS_LAST_BIT);
  assign continuous = ~mode[csp_pkg::MODE_SEL_HI] & ~mode[csp_pkg::MODE_SEL_LO];
  assign long_word = mode[csp_pkg::MODE_WL_BIT];
  assign clk_valid = ~mode[csp_pkg::MODE_CLK_HI] || (mode[3:0] == csp_pkg::CLK_EXTERNAL);
  assign in_bit = pin_func[csp_pkg::PIN_IN_BIT - 1] ? si_b : 1'b1;

  // Clock generator hookup
  assign cif.ce = ce;
  assign cif.sel = mode[3:0];
  assign cif.run = continuous | busy;
  assign cif.restart = wr_mode;

  csp_clkgen u_clkgen (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .sck_in(serial_clock_pin_in),
    .cif(cif)
  );

  // Next state of registers, shift chain and counter
  always_comb begin
    next_mode = mode;
    next_data_hi = data_hi;
    next_data_lo = data_lo;
    next_last_bit = last_bit;
    next_pin_func = pin_func;
    next_drv_od = drv_od;
    next_busy = busy;
    next_bit_cnt = bit_cnt;
    next_irq = 1'b0;
    if (busy && cif.fall) begin
      next_last_bit = data_lo[0];
    end
    if (busy && cif.rise) begin
      if (long_word) begin
        next_data_hi = {in_bit, data_hi[7:1]};
        next_data_lo = {data_hi[0], data_lo[7:1]};
      end else begin
        next_data_lo = {in_bit, data_lo[7:1]};
      end
      next_bit_cnt = bit_cnt + 5'h01;
      if (next_bit_cnt == (long_word ? csp_pkg::BITS_LONG : csp_pkg::BITS_SHORT)) begin
        next_busy = 1'b0;
        next_bit_cnt = '0;
        next_irq = 1'b1;
      end
    end
    // Software writes take the register over
    if (wr_hi) begin
      next_data_hi = wdata;
    end
    if (wr_lo) begin
      next_data_lo = wdata;
      // Start a transfer on a lower byte write
      if (!busy && !continuous && clk_valid && pin_func[csp_pkg::PIN_CLK_BIT - 1]) begin
        next_busy = 1'b1;
        next_bit_cnt = '0;
      end
    end
    if (wr_last) begin
      next_last_bit = wdata[csp_pkg::LAST_BIT_POS];
    end
    if (wr & hit(addr, csp_pkg::OFS_PIN_FUNC)) begin
      next_pin_func = wdata[csp_pkg::PIN_OUT_BIT:csp_pkg::PIN_CLK_BIT];
    end
    if (wr & hit(addr, csp_pkg::OFS_DRV_SEL)) begin
      next_drv_od = wdata[csp_pkg::DRV_OD_BIT];
    end
    if (wr_mode) begin
      next_mode = {1'b1, wdata[6:0]};
      next_bit_cnt = '0;
      next_busy = 1'b0;
      next_irq = busy;
    end
  end

  // Read data and pin drive, one cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (rd) begin
      case (addr)
        csp_pkg::OFS_MODE: next_rdata = csp_pkg::READ_ONES;
        csp_pkg::OFS_DATA_HI: next_rdata = data_hi;
        csp_pkg::OFS_DATA_LO: next_rdata = data_lo;
        csp_pkg::OFS_LAST_BIT: next_rdata = {last_bit, csp_pkg::LAST_BIT_FILL[6:0]};
        csp_pkg::OFS_PIN_FUNC: next_rdata = {4'h0, pin_func, 1'b0};
        csp_pkg::OFS_DRV_SEL: next_rdata = csp_pkg::RST_DRV_SEL | {4'h0, drv_od, 3'h0};
        default: next_rdata = '0;
      endcase
    end
    // Clock pin drives when internal and enabled
    next_sck_out = cif.lvl;
    next_sck_oe = pin_func[csp_pkg::PIN_CLK_BIT - 1] & ~mode[csp_pkg::MODE_CLK_HI];
    // Pin level from the last bit
    next_sout = last_bit;
    // Output pin only when selected; open drain drives low only
    next_sout_oe = pin_func[csp_pkg::PIN_OUT_BIT - 1] & (~drv_od | ~last_bit);
  end

  // State registers, frozen while clock enable is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode <= csp_pkg::RST_MODE;
      data_hi <= csp_pkg::RST_DATA;
      data_lo <= csp_pkg::RST_DATA;
      last_bit <= 1'b0;
      pin_func <= csp_pkg::RST_PIN_FUNC[3:1];
      drv_od <= csp_pkg::RST_DRV_SEL[3];
      busy <= 1'b0;
      bit_cnt <= '0;
      irq <= 1'b0;
      rdata <= '0;
      serial_clock_pin_out <= 1'b1;
      serial_clock_pin_oe <= 1'b0;
      serial_out_pin <= 1'b0;
      serial_out_pin_oe <= 1'b0;
      si_a <= 1'b1;
      si_b <= 1'b1;
    end else if (ce) begin
      mode <= next_mode;
      data_hi <= next_data_hi;
      data_lo <= next_data_lo;
      last_bit <= next_last_bit;
      pin_func <= next_pin_func;
      drv_od <= next_drv_od;
      busy <= next_busy;
      bit_cnt <= next_bit_cnt;
      irq <= next_irq;
      rdata <= next_rdata;
      serial_clock_pin_out <= next_sck_out;
      serial_clock_pin_oe <= next_sck_oe;
      serial_out_pin <= next_sout;
      serial_out_pin_oe <= next_sout_oe;
      si_a <= serial_in_pin;
      si_b <= si_a;
    end
  end

  assign serial_irq_flag_set = irq;

  // Checks on the core
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Mode write clears, aborts and parks the clock
  a_mode_write_clear: assert property (ce && wr_mode |=> bit_cnt == 5'h00 && !busy)
    else $error("mode write did not clear counter");
  a_abort_raises_irq: assert property (ce && wr_mode && busy |=> irq)
    else $error("abort did not request interrupt");
  a_idle_clk_high: assert property (ce && !cif.run && mode[3:0] != csp_pkg::CLK_EXTERNAL
      |=> cif.lvl)
    else $error("stopped clock not high");

  // Mode readback and idle read port
  a_mode_top_one: assert property (mode[7])
    else $error("mode top bit not one");
  a_mode_reads_ones: assert property (ce && rd && addr == 16'hffb0 |=> rdata == 8'hff)
    else $error("mode read wrong");
  a_rdata_idle: assert property (ce && !rd |=> rdata == 8'h00)
    else $error("read data not cleared");

  a_word_done_irq: assert property (ce && busy && cif.rise && !wr_mode && !wr_lo
      && bit_cnt == (long_word ? 5'h0f : 5'h07) |=> !busy && irq)
    else $error("transfer did not end at word length");
  a_irq_has_cause: assert property (irq |-> $past(busy))
    else $error("interrupt without transfer");

  // Refused starts and the free running clock
  a_cont_no_count: assert property (continuous |-> !busy)
    else $error("count running in continuous mode");
  a_cont_no_irq: assert property (ce && continuous |=> !irq)
    else $error("interrupt in continuous mode");
  a_unused_refused: assert property (ce && wr_lo && !busy && !clk_valid |=> !busy)
    else $error("start taken with unused clock code");

  // Shift chain and output stage
  a_last_follows: assert property (ce && busy && cif.fall && !wr_last
      |=> last_bit == $past(data_lo[0]))
    else $error("last bit not following output stage");
  a_short_shift: assert property (ce && busy && cif.rise && !long_word && !wr_lo && !wr_mode
      |=> data_lo == {$past(in_bit), $past(data_lo[7:1])})
    else $error("8-bit shift wrong");
  a_long_shift: assert property (ce && busy && cif.rise && long_word && !wr_hi && !wr_lo
      && !wr_mode |=> data_hi == {$past(in_bit), $past(data_hi[7:1])}
      && data_lo == {$past(data_hi[0]), $past(data_lo[7:1])})
    else $error("16-bit shift wrong");
  a_out_pin_level: assert property (ce |=> serial_out_pin == $past(last_bit))
    else $error("output pin not at last bit");

  // Clock pin drive
  a_clk_pin_dir: assert property (ce |=> serial_clock_pin_oe
      == $past(pin_func[0] & ~mode[3]))
    else $error("clock pin direction wrong");
  a_sck_follows: assert property (ce |=> serial_clock_pin_out == $past(cif.lvl))
    else $error("clock pin level not following generator");

  c_short_done: cover property (busy && !long_word ##1 !busy && irq);
  c_long_done: cover property (busy && long_word ##1 !busy && irq);
  c_abort: cover property (wr_mode && busy);
  c_ext_done: cover property (busy && mode[3:0] == csp_pkg::CLK_EXTERNAL ##1 !busy && irq);
  c_cont_fall: cover property (continuous && cif.fall);
endmodule
`default_nettype wire

// File: verification/csp_partner.sv
// Far-side serial peer: sends a word LSB first, captures the data pin, can clock.
// Assumes a resolved clock wire and the system clock for sampling.
`timescale 1ns/1ps
`default_nettype none
module csp_partner (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sck,
  input wire logic sdo,
  input wire logic load,
  input wire logic [15:0] load_data,
  input wire logic [4:0] ext_count,
  input wire logic ext_go,
  output logic sdi,
  output logic ext_clk,
  output logic ext_oe,
  output logic [15:0] rx
);
  logic sck_q;
  logic [15:0] tx;
  logic [4:0] left;
  logic [1:0] div;
  // Edge tracking, data shifting and the optional external clock
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sck_q <= 1'b1;
      tx <= 16'h0000;
      rx <= 16'h0000;
      sdi <= 1'b1;
      ext_clk <= 1'b1;
      ext_oe <= 1'b0;
      left <= 5'h00;
      div <= 2'h0;
    end else begin
      sck_q <= sck;
      // First bit stands on the data pin well before the first clock edge
      if (load) begin
        sdi <= load_data[0];
        tx <= {1'b1, load_data[15:1]};
      end
      // Next bit right after the rising edge, so it is settled at the next sample
      if (!sck_q && sck) begin
        rx <= {sdo, rx[15:1]};
        sdi <= tx[0];
        tx <= {1'b1, tx[15:1]};
      end
      if (ext_go) begin
        left <= ext_count;
        ext_oe <= 1'b1;
        div <= 2'h0;
      end else if (left != 5'h00) begin
        div <= div + 2'h1;
        if (div == 2'h3) begin
          ext_clk <= ~ext_clk;
          if (!ext_clk) begin
            left <= left - 5'h01;
          end
        end
      end else begin
        ext_oe <= 1'b0; // Clock stands high between frames
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/clocked_serial_port_tb_top.sv
// Testbench for the clocked serial port: register tasks plus a serial peer.
// Assumes pull-ups on the clock and data wires.
`timescale 1ns/1ps
`default_nettype none
module clocked_serial_port_tb_top;
  logic clk_sys, nrst, ce, wr, rd, p_load, p_go;
  logic [15:0] addr, p_data, p_rx;
  logic [7:0] wdata, rdata;
  logic sck_out, sck_oe, sdo, sdo_oe, irq, sdi, ext_clk, ext_oe;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int irq_cnt = 0;
  int n, i;
  int divs[8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
  // Resolve the two-way clock pin and the data pin
  wire sck_wire = sck_oe ? sck_out : (ext_oe ? ext_clk : 1'b1);
  wire sdo_wire = sdo_oe ? sdo : 1'b1;

  csp_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .serial_clock_pin_in(sck_wire),
    .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe), .serial_in_pin(sdi),
    .serial_out_pin(sdo), .serial_out_pin_oe(sdo_oe), .serial_irq_flag_set(irq));
  csp_partner u_peer (.clk_sys(clk_sys), .nrst(nrst), .sck(sck_wire), .sdo(sdo_wire),
    .load(p_load), .load_data(p_data), .ext_count(5'h08), .ext_go(p_go), .sdi(sdi),
    .ext_clk(ext_clk), .ext_oe(ext_oe), .rx(p_rx));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Interrupt pulse count and hang guard
  always @(posedge clk_sys) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  task results;
    $display("bad_count=%0d checked=%0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: bit %b want %b", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk_val({8'h00, rdata}, {8'h00, e});
  endtask
  task wait_irq(input int lim);
    int s;
    s = irq_cnt;
    n = 0;
    while (irq_cnt == s && n < lim) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk_bit(irq_cnt != s, 1'b1);
  endtask
  task wait_fall(output int k);
    logic p;
    k = 0;
    p = 1'b0;
    while (k < 3000 && !(p && !sck_wire)) begin
      p = sck_wire;
      @(posedge clk_sys);
      #1 k++;
    end
  endtask
  task peer_load(input logic [15:0] d);
    @(posedge clk_sys);
    p_data <= d;
    p_load <= 1'b1;
    @(posedge clk_sys);
    p_load <= 1'b0;
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    p_load = 1'b0;
    p_go = 1'b0;
    p_data = 16'h0000;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk(csp_pkg::OFS_MODE, 8'hff);
    rd_chk(csp_pkg::OFS_PIN_FUNC, 8'h00);
    rd_chk(csp_pkg::OFS_DRV_SEL, 8'h97);
    rd_chk(16'hffb4, 8'h00);
    // Continuous clock periods, reset default first
    wr_reg(csp_pkg::OFS_PIN_FUNC, 8'h0e);
    wait_fall(n);
    wait_fall(n);
    chk_val(n[15:0], divs[0][15:0]);
    for (i = 1; i < 8; i++) begin
      wr_reg(csp_pkg::OFS_MODE, (i % 2 == 1) ? (8'h40 | i[7:0]) : i[7:0]);
      wait_fall(n);
      wait_fall(n);
      chk_val(n[15:0], divs[i][15:0]);
    end
    // Starts refused in continuous mode and with an unused clock code
    i = irq_cnt;
    wr_reg(csp_pkg::OFS_DATA_LO, 8'h55);
    repeat (300) @(posedge clk_sys);
    wr_reg(csp_pkg::OFS_MODE, 8'h18);
    wr_reg(csp_pkg::OFS_DATA_LO, 8'h55);
    repeat (300) @(posedge clk_sys);
    chk_val(irq_cnt[15:0], i[15:0]);
    // Eight-bit exchange at division 8
    wr_reg(csp_pkg::OFS_MODE, 8'h15);
    peer_load(16'h00a5);
    wr_reg(csp_pkg::OFS_DATA_LO, 8'hbc);
    wait_irq(400);
    rd_chk(csp_pkg::OFS_DATA_LO, 8'ha5);
    rd_chk(csp_pkg::OFS_LAST_BIT, 8'hff);
    chk_bit(sdo, 1'b1);
    chk_val({8'h00, p_rx[15:8]}, 16'h00bc);
    // Sixteen-bit exchange
    wr_reg(csp_pkg::OFS_MODE, 8'h55);
    peer_load(16'hbeef);
    wr_reg(csp_pkg::OFS_DATA_HI, 8'h12);
    wr_reg(csp_pkg::OFS_DATA_LO, 8'h34);
    wait_irq(400);
    rd_chk(csp_pkg::OFS_DATA_HI, 8'hbe);
    rd_chk(csp_pkg::OFS_DATA_LO, 8'hef);
    chk_val(p_rx, 16'h1234);
    // Abort by a mode write in mid-transfer
    wr_reg(csp_pkg::OFS_MODE, 8'h15);
    wr_reg(csp_pkg::OFS_DATA_LO, 8'h0f);
    repeat (12) @(posedge clk_sys);
    wr_reg(csp_pkg::OFS_MODE, 8'h15);
    wait_irq(4);
    i = irq_cnt;
    n = 0;
    repeat (40) begin
      @(posedge clk_sys);
      #1 if (sck_wire !== 1'b1) n++;
    end
    chk_val(n[15:0], 16'h0000);
    chk_val(irq_cnt[15:0], i[15:0]);
    // Transmit-only shifts in ones
    wr_reg(csp_pkg::OFS_PIN_FUNC, 8'h0a);
    wr_reg(csp_pkg::OFS_DATA_LO, 8'h00);
    wait_irq(400);
    rd_chk(csp_pkg::OFS_DATA_LO, 8'hff);
    // Open drain: the data pin is released while the last bit is high
    wr_reg(csp_pkg::OFS_DRV_SEL, 8'h08);
    rd_chk(csp_pkg::OFS_DRV_SEL, 8'h9f);
    wr_reg(csp_pkg::OFS_LAST_BIT, 8'h80);
    repeat (3) @(posedge clk_sys);
    #1 chk_bit(sdo_oe, 1'b0);
    chk_bit(sdo_wire, 1'b1);
    wr_reg(csp_pkg::OFS_LAST_BIT, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1 chk_bit(sdo_oe, 1'b1);
    chk_bit(sdo, 1'b0);
    wr_reg(csp_pkg::OFS_DRV_SEL, 8'h00);
    // Receive-only releases the data pin
    wr_reg(csp_pkg::OFS_PIN_FUNC, 8'h06);
    repeat (3) @(posedge clk_sys);
    chk_bit(sdo_oe, 1'b0);
    // External clock from the peer
    wr_reg(csp_pkg::OFS_PIN_FUNC, 8'h0e);
    wr_reg(csp_pkg::OFS_MODE, 8'h1f);
    peer_load(16'h005a);
    wr_reg(csp_pkg::OFS_DATA_LO, 8'h00);
    @(posedge clk_sys);
    p_go <= 1'b1;
    @(posedge clk_sys);
    p_go <= 1'b0;
    #1 chk_bit(sck_oe, 1'b0);
    wait_irq(400);
    rd_chk(csp_pkg::OFS_DATA_LO, 8'h5a);
    results();
  end
endmodule
`default_nettype wire
